// ===== hdl/spms_cfg.svh
// constants for the serial port master/slave pair
`ifndef SPMS_CFG_SVH
`define SPMS_CFG_SVH
// =====================================================================
// register offsets (byte index on the register port)
`define SPMS_REG_CTRL1  3'h0
`define SPMS_REG_CTRL2  3'h1
`define SPMS_REG_RATE   3'h2
`define SPMS_REG_STAT   3'h3
`define SPMS_REG_DATA   3'h4
// =====================================================================
// field positions
`define SPMS_C1_EN      6
`define SPMS_C1_MST     4
`define SPMS_C1_CLOCK_IDLE_LEVEL    3
`define SPMS_C1_CLOCK_EDGE_PHASE    2
`define SPMS_C1_SELO    1
`define SPMS_C1_LSBF    0
`define SPMS_C2_FLTEN   4
`define SPMS_C2_BIOE    3
`define SPMS_C2_SWIRE   0
`define SPMS_ST_RXF     7
`define SPMS_ST_TXE     5
`define SPMS_ST_FLT     4
// =====================================================================
// reset values and writable masks
`define SPMS_C1_RST     8'h04
`define SPMS_C1_MASK    8'h5F
`define SPMS_C2_RST     8'h00
`define SPMS_C2_MASK    8'h19
`define SPMS_RATE_RST   8'h00
`define SPMS_RATE_MASK  8'h77
// =====================================================================
// timing
`define SPMS_CLK_NS      25
`define SPMS_FAR_HALF_NS 500
`define SPMS_FAR_HALF_CYC ((`SPMS_FAR_HALF_NS + `SPMS_CLK_NS - 1) / `SPMS_CLK_NS)
`endif

// ===== hdl/spms_dev.sv
// device end: register-driven serial port, master or slave
`timescale 1ns/1ps
`include "spms_cfg.svh"
module spms_dev
    import spms_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    spms_if.dev             pins,
    input  wire logic [2:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic      [3:0] pin_release
);
    spms_state_t state_r;
    spms_state_t state_nxt;
    logic [7:0]  ctrl1_r;
    logic [7:0]  ctrl2_r;
    logic [7:0]  rate_r;
    logic [7:0]  txbuf_r;
    logic [7:0]  rxbuf_r;
    logic        tx_empty_r;
    logic        rx_full_r;
    logic        fault_r;
    logic [7:0]  sh_r;
    logic [7:0]  sh_nxt;
    logic [2:0]  idx_r;
    logic        dout_r;
    logic        sck_r;
    logic        sck_nxt;
    logic [10:0] div_cnt_r;
    logic [10:0] div_nxt;
    logic [3:0]  s1_r;
    logic [3:0]  s2_r;
    logic        sck_prev_r;
    logic        ss_prev_r;
    logic [3:0]  pin_in;
    // =================================================================
    // control fields
    wire       en     = ctrl1_r[`SPMS_C1_EN];
    wire       mst    = ctrl1_r[`SPMS_C1_MST];
    wire       clock_idle_level   = ctrl1_r[`SPMS_C1_CLOCK_IDLE_LEVEL];
    wire       clock_edge_phase   = ctrl1_r[`SPMS_C1_CLOCK_EDGE_PHASE];
    wire       selo   = ctrl1_r[`SPMS_C1_SELO];
    wire       lsbf   = ctrl1_r[`SPMS_C1_LSBF];
    wire       flten  = ctrl2_r[`SPMS_C2_FLTEN];
    wire       bioe   = ctrl2_r[`SPMS_C2_BIOE];
    wire       swire  = ctrl2_r[`SPMS_C2_SWIRE];
    wire [2:0] pre_f  = rate_r[6:4];
    wire [2:0] dsel_f = rate_r[2:0];
    // =================================================================
    // register port decode
    wire wr_c1   = reg_wr & (reg_addr == `SPMS_REG_CTRL1);
    wire wr_c2   = reg_wr & (reg_addr == `SPMS_REG_CTRL2);
    wire wr_rate = reg_wr & (reg_addr == `SPMS_REG_RATE);
    wire wr_data = reg_wr & (reg_addr == `SPMS_REG_DATA);
    wire rd_stat = reg_rd & (reg_addr == `SPMS_REG_STAT);
    wire rd_data = reg_rd & (reg_addr == `SPMS_REG_DATA);
    wire [7:0] stat_v = {rx_full_r, 1'b0, tx_empty_r, fault_r, 4'h0};
    wire [7:0] rd_mux = (reg_addr == `SPMS_REG_CTRL1) ? ctrl1_r :
                        (reg_addr == `SPMS_REG_CTRL2) ? ctrl2_r :
                        (reg_addr == `SPMS_REG_RATE)  ? rate_r  :
                        (reg_addr == `SPMS_REG_STAT)  ? stat_v  :
                        (reg_addr == `SPMS_REG_DATA)  ? rxbuf_r : 8'h00;
    // =================================================================
    // input synchronisers
    assign pin_in = {pins.ss_n, pins.miso, pins.mosi, pins.sck};
    genvar gi;
    for (gi = 0; gi < 4; gi++) begin : g_sync
        always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
                s1_r[gi] <= 1'b1;
                s2_r[gi] <= 1'b1;
            end else begin
                s1_r[gi] <= pin_in[gi];
                s2_r[gi] <= s1_r[gi];
            end
        end
    end
    // =================================================================
    // bit-rate divider: half bit = (prescale + 1) * 2^rate_divide bus clocks
    // limitation: a far slave's reply crosses both synchronisers, keep half bit >= 6
    wire [10:0] half_len = ({8'h00, pre_f} + 11'h001) << dsel_f;
    wire        tick     = div_cnt_r == half_len - 11'h001;
    wire        run      = state_r == SPMS_RUN;
    // =================================================================
    // edge and transfer events
    wire       sel      = ~s2_r[3];
    wire       fault_in = en & mst & flten & ~selo & ~s2_r[3];
    wire       m_lead   = run & tick & (sck_r == clock_idle_level);
    wire       m_trail  = run & tick & (sck_r != clock_idle_level);
    wire       s_lead   = sel & (sck_prev_r == clock_idle_level) & (s2_r[0] != clock_idle_level);
    wire       s_trail  = sel & (sck_prev_r != clock_idle_level) & (s2_r[0] == clock_idle_level);
    wire       lead     = en & (mst ? m_lead : s_lead);
    wire       trail    = en & (mst ? m_trail : s_trail);
    wire       done     = trail & (idx_r == 3'h7);
    wire       m_start  = en & mst & ~fault_in & (state_r == SPMS_IDLE) & ~tx_empty_r;
    wire       s_load   = en & ~mst & ((ss_prev_r & ~s2_r[3]) | (done & sel));
    wire       load     = m_start | s_load;
    // master-in vs master-out pin chosen by role and single-wire mode
    wire       din      = (mst ^ swire) ? s2_r[2] : s2_r[1];
    wire [2:0] pos      = lsbf ? idx_r : ~idx_r;
    wire [2:0] npos     = lsbf ? idx_r + 3'h1 : ~(idx_r + 3'h1);
    wire [2:0] first    = lsbf ? 3'h0 : 3'h7;
    wire       samp     = clock_edge_phase ? trail : lead;
    wire       outn     = clock_edge_phase ? lead : trail;
    wire [7:0] load_v   = tx_empty_r ? sh_nxt : txbuf_r;
    // =================================================================
    // pins
    assign pins.dev_sck_o   = sck_r;
    assign pins.dev_sck_oe  = en & mst;
    assign pins.dev_mosi_o  = dout_r;
    assign pins.dev_mosi_oe = en & mst & (~swire | bioe);
    assign pins.dev_miso_o  = dout_r;
    assign pins.dev_miso_oe = en & ~mst & sel & (~swire | bioe);
    assign pins.dev_ss_o    = state_r == SPMS_IDLE;
    assign pins.dev_ss_oe   = en & mst & flten & selo;
    assign pin_release[0]   = ~en;
    assign pin_release[1]   = ~en | (swire & ~mst);
    assign pin_release[2]   = ~en | (swire & mst);
    assign pin_release[3]   = ~en | (mst & ~flten);
    // =================================================================
    // master sequencing
    always_comb begin
        state_nxt = state_r;
        div_nxt   = tick ? 11'h000 : div_cnt_r + 11'h001;
        sck_nxt   = sck_r;
        unique case (state_r)
            SPMS_IDLE: begin
                div_nxt = 11'h000;
                sck_nxt = clock_idle_level;
                if (m_start) state_nxt = SPMS_RUN;
            end
            SPMS_RUN: begin
                if (tick) sck_nxt = ~sck_r;
                if (done) state_nxt = SPMS_END;
            end
            SPMS_END: if (tick) state_nxt = SPMS_IDLE;
        endcase
        // disable or fault aborts mid-byte
        if (!en || !mst || fault_in) begin
            state_nxt = SPMS_IDLE;
            div_nxt   = 11'h000;
            sck_nxt   = clock_idle_level;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r   <= SPMS_IDLE;
            div_cnt_r <= 11'h000;
            sck_r     <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            div_cnt_r <= div_nxt;
            sck_r     <= sck_nxt;
        end
    end
    // =================================================================
    // shift register: one register serves both directions
    always_comb begin
        sh_nxt = sh_r;
        if (samp) sh_nxt[pos] = din;
    end
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sh_r       <= 8'h00;
            idx_r      <= 3'h0;
            dout_r     <= 1'b0;
            sck_prev_r <= 1'b1;
            ss_prev_r  <= 1'b1;
        end else begin
            sck_prev_r <= s2_r[0];
            ss_prev_r  <= s2_r[3];
            if (!en || fault_in) begin
                sh_r   <= 8'h00;
                idx_r  <= 3'h0;
                dout_r <= 1'b0;
            end else if (load) begin
                sh_r  <= load_v;
                idx_r <= 3'h0;
                if (!clock_edge_phase) dout_r <= load_v[first];
            end else if (!mst && !sel) begin
                idx_r <= 3'h0;
            end else begin
                sh_r <= sh_nxt;
                if (trail) idx_r <= idx_r + 3'h1;
                if (outn) dout_r <= clock_edge_phase ? sh_r[pos] : sh_r[npos];
            end
        end
    end
    // =================================================================
    // buffers and flags
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            txbuf_r    <= 8'h00;
            rxbuf_r    <= 8'h00;
            tx_empty_r <= 1'b1;
            rx_full_r  <= 1'b0;
        end else if (!en) begin
            txbuf_r    <= 8'h00;
            rxbuf_r    <= 8'h00;
            tx_empty_r <= 1'b1;
            rx_full_r  <= 1'b0;
        end else begin
            if (wr_data && tx_empty_r) begin
                txbuf_r    <= reg_wdata;
                tx_empty_r <= 1'b0;
            end else if (load && !tx_empty_r) begin
                tx_empty_r <= 1'b1;
            end
            // set beats the read clear; an unread byte is kept on overrun
            if (done) begin
                rx_full_r <= 1'b1;
                if (!rx_full_r) rxbuf_r <= sh_nxt;
            end else if (rd_data) begin
                rx_full_r <= 1'b0;
            end
        end
    end
    // =================================================================
    // software registers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl1_r   <= `SPMS_C1_RST;
            ctrl2_r   <= `SPMS_C2_RST;
            rate_r    <= `SPMS_RATE_RST;
            fault_r   <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            if (wr_c1) ctrl1_r <= reg_wdata & `SPMS_C1_MASK;
            if (fault_in) ctrl1_r[`SPMS_C1_MST] <= 1'b0;
            if (wr_c2) ctrl2_r <= reg_wdata & `SPMS_C2_MASK;
            if (wr_rate) rate_r <= reg_wdata & `SPMS_RATE_MASK;
            if (fault_in) fault_r <= 1'b1;
            else if (rd_stat) fault_r <= 1'b0;
            if (reg_rd) reg_rdata <= rd_mux;
        end
    end
endmodule

// ===== hdl/spms_far.sv
// far end: plain serial peer acting as master or slave, msb first
`timescale 1ns/1ps
`include "spms_cfg.svh"
module spms_far
    import spms_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    spms_if.far             pins,
    input  wire logic       far_master,
    input  wire logic       far_clock_idle_level,
    input  wire logic       far_clock_edge_phase,
    input  wire logic [7:0] tx_data,
    input  wire logic       start,
    output logic            busy,
    output logic      [7:0] rx_data,
    output logic            rx_valid
);
    localparam logic [7:0] HALF = 8'(`SPMS_FAR_HALF_CYC);
    spms_state_t state_r;
    spms_state_t state_nxt;
    logic [7:0]  cnt_r;
    logic [3:0]  s1_r;
    logic [3:0]  s2_r;
    logic        sck_prev_r;
    logic        ss_prev_r;
    logic        sck_r;
    logic [7:0]  sh_r;
    logic [7:0]  sh_nxt;
    logic [2:0]  idx_r;
    logic        dout_r;
    logic [3:0]  pin_in;
    // =================================================================
    // input synchronisers
    assign pin_in = {pins.ss_n, pins.miso, pins.mosi, pins.sck};
    genvar gi;
    for (gi = 0; gi < 4; gi++) begin : g_sync
        always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
                s1_r[gi] <= 1'b1;
                s2_r[gi] <= 1'b1;
            end else begin
                s1_r[gi] <= pin_in[gi];
                s2_r[gi] <= s1_r[gi];
            end
        end
    end
    // =================================================================
    // edge decode
    wire       tick    = cnt_r == HALF - 8'h01;
    wire       run     = state_r == SPMS_RUN;
    wire       sel     = ~s2_r[3];
    wire       s_lead  = sel & (sck_prev_r == far_clock_idle_level) & (s2_r[0] != far_clock_idle_level);
    wire       s_trail = sel & (sck_prev_r != far_clock_idle_level) & (s2_r[0] == far_clock_idle_level);
    wire       lead    = far_master ? (run & tick & (sck_r == far_clock_idle_level)) : s_lead;
    wire       trail   = far_master ? (run & tick & (sck_r != far_clock_idle_level)) : s_trail;
    wire       done    = trail & (idx_r == 3'h7);
    wire       m_start = far_master & start & (state_r == SPMS_IDLE);
    wire       s_load  = ~far_master & ss_prev_r & ~s2_r[3];
    wire       load    = m_start | s_load;
    wire       din     = far_master ? s2_r[2] : s2_r[1];
    wire [2:0] pos     = ~idx_r;
    wire [2:0] npos    = ~(idx_r + 3'h1);
    wire       samp    = far_clock_edge_phase ? trail : lead;
    wire       outn    = far_clock_edge_phase ? lead : trail;
    assign busy = state_r != SPMS_IDLE;
    // =================================================================
    // pins
    assign pins.far_sck_o   = sck_r;
    assign pins.far_sck_oe  = far_master;
    assign pins.far_mosi_o  = dout_r;
    assign pins.far_mosi_oe = far_master;
    assign pins.far_miso_o  = dout_r;
    assign pins.far_miso_oe = ~far_master & sel;
    assign pins.far_ss_o    = ~busy;
    assign pins.far_ss_oe   = far_master;
    // =================================================================
    // master sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            SPMS_IDLE: if (m_start) state_nxt = SPMS_RUN;
            SPMS_RUN:  if (done) state_nxt = SPMS_END;
            SPMS_END:  if (tick) state_nxt = SPMS_IDLE;
        endcase
        if (!far_master) state_nxt = SPMS_IDLE;
        sh_nxt = sh_r;
        if (samp) sh_nxt[pos] = din;
    end
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= SPMS_IDLE;
            cnt_r   <= 8'h00;
            sck_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= (state_r == SPMS_IDLE || tick) ? 8'h00 : cnt_r + 8'h01;
            sck_r   <= (run && tick) ? ~sck_r : (run ? sck_r : far_clock_idle_level);
        end
    end
    // =================================================================
    // shifter
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sh_r       <= 8'h00;
            idx_r      <= 3'h0;
            dout_r     <= 1'b0;
            sck_prev_r <= 1'b1;
            ss_prev_r  <= 1'b1;
            rx_data    <= 8'h00;
            rx_valid   <= 1'b0;
        end else begin
            sck_prev_r <= s2_r[0];
            ss_prev_r  <= s2_r[3];
            rx_valid   <= done;
            if (done) rx_data <= sh_nxt;
            if (load) begin
                sh_r  <= tx_data;
                idx_r <= 3'h0;
                if (!far_clock_edge_phase) dout_r <= tx_data[7];
            end else if (!far_master && !sel) begin
                idx_r <= 3'h0;
            end else begin
                sh_r <= sh_nxt;
                if (trail) idx_r <= idx_r + 3'h1;
                if (outn) dout_r <= far_clock_edge_phase ? sh_r[pos] : sh_r[npos];
            end
        end
    end
endmodule

// ===== hdl/spms_if.sv
// four-wire serial link joining the device end and the far end
`timescale 1ns/1ps
interface spms_if;
    logic dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe;
    logic dev_miso_o, dev_miso_oe, dev_ss_o, dev_ss_oe;
    logic far_sck_o, far_sck_oe, far_mosi_o, far_mosi_oe;
    logic far_miso_o, far_miso_oe, far_ss_o, far_ss_oe;
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
    // undriven lines float high, as with a pull-up
    assign sck  = dev_sck_oe  ? dev_sck_o  : (far_sck_oe  ? far_sck_o  : 1'b1);
    assign mosi = dev_mosi_oe ? dev_mosi_o : (far_mosi_oe ? far_mosi_o : 1'b1);
    assign miso = dev_miso_oe ? dev_miso_o : (far_miso_oe ? far_miso_o : 1'b1);
    assign ss_n = dev_ss_oe   ? dev_ss_o   : (far_ss_oe   ? far_ss_o   : 1'b1);
    modport dev (output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe,
                 output dev_miso_o, dev_miso_oe, dev_ss_o, dev_ss_oe,
                 input  sck, mosi, miso, ss_n);
    modport far (output far_sck_o, far_sck_oe, far_mosi_o, far_mosi_oe,
                 output far_miso_o, far_miso_oe, far_ss_o, far_ss_oe,
                 input  sck, mosi, miso, ss_n);
endinterface

// ===== hdl/spms_pkg.sv
// types shared by both ends of the serial port
package spms_pkg;
    typedef enum logic [1:0] {SPMS_IDLE, SPMS_RUN, SPMS_END} spms_state_t;
endpackage

// ===== sim/spms_monitor.sv
// assertion monitor for the serial link between both ends
`timescale 1ns/1ps
module spms_monitor
    import spms_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic dev_sck_o,
    input wire logic dev_sck_oe,
    input wire logic dev_mosi_oe,
    input wire logic dev_miso_oe,
    input wire logic dev_ss_o,
    input wire logic dev_ss_oe,
    input wire logic far_sck_oe,
    input wire logic far_mosi_oe,
    input wire logic far_miso_oe,
    input wire logic sck,
    input wire logic ss_n
);
    // ==========================================
    // clock edges seen inside a device frame
    logic [4:0] edges_r;
    logic [4:0] edges_nxt;
    logic       sck_q_r;
    assign edges_nxt = dev_ss_o ? 5'h00 : edges_r + {4'h0, sck_q_r ^ dev_sck_o};
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            edges_r <= 5'h00;
            sck_q_r <= 1'b0;
        end else begin
            edges_r <= edges_nxt;
            sck_q_r <= dev_sck_o;
        end
    end
    default clocking mon_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    // ==========================================
    // link properties
    AST_ONE_CLOCK: assert property (!(dev_sck_oe && far_sck_oe))
        else $error("clock line driven by both ends");
    AST_SLAVE_NO_CLOCK: assert property (dev_miso_oe |-> !dev_sck_oe)
        else $error("slave drives the clock line");
    AST_UNSELECTED_QUIET: assert property (ss_n [*4] |-> !dev_miso_oe)
        else $error("slave drives data while not selected");
    AST_AUTO_SELECT_MASTER: assert property (dev_ss_oe |-> dev_sck_oe)
        else $error("select output driven outside master role");
    AST_SELECT_WHOLE_BYTE: assert property ($fell(dev_ss_o) && dev_ss_oe |-> !dev_ss_o [*8])
        else $error("select returned high too early");
    AST_SIXTEEN_EDGES: assert property ($rose(dev_ss_o) && dev_ss_oe |-> edges_r == 5'h10)
        else $error("frame without sixteen clock edges");
    AST_CLOCK_IDLE: assert property (dev_ss_oe && dev_ss_o && $past(dev_ss_o) && $past(dev_sck_oe, 2)
        && dev_sck_oe |-> $stable(dev_sck_o))
        else $error("clock moved outside a frame");
    AST_MOSI_ONE_DRIVER: assert property (!(dev_mosi_oe && far_mosi_oe))
        else $error("master-out line driven by both ends");
    AST_MISO_ONE_DRIVER: assert property (!(dev_miso_oe && far_miso_oe))
        else $error("master-in line driven by both ends");
    cover property ($fell(dev_ss_o) && dev_ss_oe);
    cover property (far_sck_oe && $changed(sck));
    cover property (dev_miso_oe && !ss_n);
endmodule

// ===== sim/tb.sv
// self-checking bench joining the device end and the far end
`timescale 1ns/1ps
`include "spms_cfg.svh"
module tb
    import spms_pkg::*;
;
    logic       sys_clk = 1'b0;
    logic       rst_b = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [3:0] pin_release;
    logic       far_master = 1'b0;
    logic       far_clock_idle_level = 1'b0;
    logic       far_clock_edge_phase = 1'b0;
    logic [7:0] far_tx = 8'h00;
    logic       far_start = 1'b0;
    logic       far_busy;
    logic [7:0] far_rx;
    int         num_errors = 0;
    int         n_tests = 0;
    logic [7:0] t_c1 [8] = '{8'h52, 8'h50, 8'h52, 8'h52, 8'h52, 8'h00, 8'h40, 8'h40};
    logic [7:0] t_c2 [8] = '{8'h00, 8'h10, 8'h10, 8'h19, 8'h11, 8'h00, 8'h00, 8'h01};
    logic [7:0] t_ex [8] = '{8'h86, 8'h06, 8'h0E, 8'h4E, 8'h4C, 8'hF0, 8'h00, 8'h20};
    spms_if link();
    spms_dev spms_dev_inst (.sys_clk(sys_clk), .rst_b(rst_b), .pins(link.dev), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_release(pin_release));
    spms_far spms_far_inst (.sys_clk(sys_clk), .rst_b(rst_b), .pins(link.far), .far_master(far_master),
        .far_clock_idle_level(far_clock_idle_level), .far_clock_edge_phase(far_clock_edge_phase), .tx_data(far_tx), .start(far_start), .busy(far_busy),
        .rx_data(far_rx), .rx_valid());
    spms_monitor spms_monitor_inst (.sys_clk(sys_clk), .rst_b(rst_b), .dev_sck_o(link.dev_sck_o),
        .dev_sck_oe(link.dev_sck_oe), .dev_mosi_oe(link.dev_mosi_oe), .dev_miso_oe(link.dev_miso_oe),
        .dev_ss_o(link.dev_ss_o), .dev_ss_oe(link.dev_ss_oe), .far_sck_oe(link.far_sck_oe),
        .far_mosi_oe(link.far_mosi_oe), .far_miso_oe(link.far_miso_oe), .sck(link.sck), .ss_n(link.ss_n));
    always #12.5 sys_clk = ~sys_clk;
    // ==========================================
    // helpers
    function automatic logic [7:0] rev(input logic [7:0] x);
        for (int i = 0; i < 8; i++) rev[i] = x[7 - i];
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        cyc(1);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] e);
        cyc(1);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        chk($sformatf("reg%0d", a), reg_rdata, e);
    endtask
    // bounded wait for one select-low frame, counting clock edges
    task automatic wait_frame(output int e, output int span);
        int   c;
        int   t1;
        logic ps;
        logic low;
        e = 0;
        t1 = 0;
        span = 0;
        low = 1'b0;
        ps = link.sck;
        for (c = 0; c < 3000 && !(low && link.ss_n === 1'b1); c++) begin
            @(posedge sys_clk);
            #1;
            if (link.sck !== ps) begin
                e++;
                if (e == 1) t1 = c;
                span = c - t1;
            end
            ps = link.sck;
            low = low | (link.ss_n === 1'b0);
        end
        if (c == 3000) begin
            num_errors++;
            wrap_up();
        end
    endtask
    task automatic frame_m(input logic [7:0] tx, input logic [7:0] ftx, input int h, input logic lsb);
        int e;
        int span;
        far_tx = ftx;
        wr(`SPMS_REG_DATA, tx);
        wait_frame(e, span);
        chk("edges", 16'(e), 16'h0010);
        chk("span", 16'(span), 16'(15 * h));
        chk("far_rx", far_rx, lsb ? rev(tx) : tx);
        rdc(`SPMS_REG_STAT, 8'hA0);
        rdc(`SPMS_REG_DATA, lsb ? rev(ftx) : ftx);
        rdc(`SPMS_REG_STAT, 8'h20);
    endtask
    // ==========================================
    // main sequence
    initial begin
        int c;
        repeat (12) @(posedge sys_clk);
        #2;
        rst_b = 1'b1;
        rdc(`SPMS_REG_CTRL1, 8'h04);
        rdc(`SPMS_REG_CTRL2, 8'h00);
        rdc(`SPMS_REG_RATE, 8'h00);
        rdc(`SPMS_REG_STAT, 8'h20);
        rdc(3'h7, 8'h00);
        chk("release", pin_release, 4'hF);
        for (int a = 0; a < 3; a++) begin
            wr(3'(a), 8'hFF);
            rdc(3'(a), a == 0 ? 8'h5F : (a == 1 ? 8'h19 : 8'h77));
            wr(3'(a), 8'h00);
        end
        $display("registers test done");
        for (int r = 0; r < 8; r++) begin
            wr(`SPMS_REG_CTRL2, t_c2[r]);
            wr(`SPMS_REG_CTRL1, t_c1[r]);
            cyc(4);
            chk("pins", {pin_release, link.dev_ss_oe, link.dev_sck_oe, link.dev_mosi_oe, link.dev_miso_oe},
                t_ex[r]);
        end
        $display("pin routing test done");
        wr(`SPMS_REG_CTRL1, 8'h00);
        wr(`SPMS_REG_CTRL2, 8'h10);
        for (int i = 0; i < 8; i++) begin
            far_clock_idle_level = i[1];
            far_clock_edge_phase = i[0];
            // half bits of 12 and 8 clocks cover the far slave's synchroniser round trip
            wr(`SPMS_REG_RATE, i[2] ? 8'h22 : 8'h31);
            wr(`SPMS_REG_CTRL1, 8'h52 | {4'h0, i[1], i[0], 1'b0, i[2]});
            cyc(2);
            chk("sck_idle", link.sck, i[1]);
            frame_m(8'hA5 ^ 8'(i), 8'h3C + 8'(i), i[2] ? 12 : 8, i[2]);
            wr(`SPMS_REG_CTRL1, 8'h00);
        end
        $display("master test done");
        far_clock_idle_level = 1'b1;
        far_clock_edge_phase = 1'b0;
        far_master = 1'b1;
        wr(`SPMS_REG_CTRL1, 8'h48);
        wr(`SPMS_REG_DATA, 8'h96);
        far_tx = 8'h5A;
        cyc(40);
        chk("slave_sck_oe", link.dev_sck_oe, 1'b0);
        rdc(`SPMS_REG_STAT, 8'h00);
        far_start = 1'b1;
        cyc(1);
        far_start = 1'b0;
        for (c = 0; c < 3000 && far_busy !== 1'b0; c++) cyc(1);
        if (c == 3000) begin
            num_errors++;
            wrap_up();
        end
        cyc(4);
        chk("far_rx", far_rx, 8'h96);
        rdc(`SPMS_REG_DATA, 8'h5A);
        $display("slave test done");
        far_master = 1'b0;
        // slowest rate keeps the master mid-byte when the disable aborts it and clears the buffers
        wr(`SPMS_REG_RATE, 8'h77);
        wr(`SPMS_REG_CTRL1, 8'h52);
        wr(`SPMS_REG_DATA, 8'hE1);
        wr(`SPMS_REG_DATA, 8'h33);
        cyc(20);
        rdc(`SPMS_REG_STAT, 8'h00);
        wr(`SPMS_REG_CTRL1, 8'h00);
        rdc(`SPMS_REG_STAT, 8'h20);
        rdc(`SPMS_REG_DATA, 8'h00);
        chk("release", pin_release, 4'hF);
        $display("abort test done");
        wrap_up();
    end
endmodule
